// *** design/stpf_pkg.sv ***
// Package with constants and types for the spanning tree port filter
package stpf_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_PORTS  = 12;  // Switch ports, CPU port included
  localparam int PORT_W     = 4;   // Port index width
  localparam int NUM_INST   = 16;  // Tree instances
  localparam int INST_W     = 4;   // Tree instance index width
  localparam int CNT_W      = 32;  // Drop counter width
  localparam int MAC_W      = 48;  // MAC address width
  localparam int NUM_PROTO  = 3;   // Protocol address match slots

  // ************************************************************
  // Protocol multicast addresses sent to the CPU by default
  // ************************************************************
  localparam logic [MAC_W-1:0] PROTO_ADDR0 = 48'h0180C2000000;
  localparam logic [MAC_W-1:0] PROTO_ADDR1 = 48'h01000CCCCCCD;

  // ************************************************************
  // Reset values and counter constants
  // ************************************************************
  localparam logic [NUM_PROTO-1:0] PROTO_EN_RESET   = 3'h3;  // Both fixed addresses on
  localparam logic [MAC_W-1:0]     PROTO_ADDR_RESET = 48'h000000000000;
  localparam logic [CNT_W-1:0]     CNT_MAX          = 32'hFFFFFFFF;
  localparam logic [CNT_W-1:0]     CNT_ONE          = 32'h00000001;
  localparam logic [CNT_W-1:0]     CNT_ZERO         = 32'h00000000;

  // ************************************************************
  // Plain spanning tree port states
  // ************************************************************
  typedef enum logic [2:0] {
    STPF_DISABLED   = 3'b000,
    STPF_BLOCKING   = 3'b001,
    STPF_LISTENING  = 3'b010,
    STPF_LEARNING   = 3'b011,
    STPF_FORWARDING = 3'b100
  } stpf_stp_type;

  // ************************************************************
  // Tree instance port states
  // ************************************************************
  typedef enum logic [1:0] {
    STPF_I_FORWARDING = 2'b00,
    STPF_I_LEARNING   = 2'b01,
    STPF_I_DISCARDING = 2'b10
  } stpf_inst_type;

endpackage : stpf_pkg

// *** design/stpf_sat_counter.sv ***
// Saturating event counter used for the drop counters
`timescale 1ns/1ps

module stpf_sat_counter
  import stpf_pkg::*;
(
  input  wire logic             clk,    // Core clock
  input  wire logic             nrst,   // Asynchronous reset, active low
  input  wire logic             inc,    // One-cycle increment request
  output logic [CNT_W-1:0]      value   // Current count
);

  // Held at maximum so software never sees a silent wrap
  wire logic at_max = (value == CNT_MAX);

  // ************************************************************
  // Count register
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      value <= CNT_ZERO;
    end else if (inc && !at_max) begin
      value <= value + CNT_ONE;  // RL18
    end
  end

endmodule : stpf_sat_counter

// *** design/stpf_port_filter.sv ***
// Spanning tree port filter: state tables, frame decision and drop counters
// Operation
// RL1 - Filtering off after reset until enabled
// RL2 - Protocol multicast addresses go to CPU
// RL3 - CPU frames bypass egress state when enabled
// RL4 - Separate ingress and egress state per port
// RL5 - Plain tree users set instance states Forwarding
// RL6 - Egress state never affects learning
// RL7 - Blocking/Listening: no learning, no forwarding, count
// RL8 - Learning: learn, no forwarding, count drop
// RL9 - Forwarding/Disabled: learn and switch normally
// RL10 - VLAN entry index selects tree instance tables
// RL11 - Instance users set plain states Disabled
// RL12 - Count drop by direction and state
// RL13 - Ingress counters shared, egress counter per port
// RL14 - Instance Learning/Discarding map to ingress counters
// RL15 - Egress instance drops use port egress counter
// RL16 - Ingress Learning drop still allows learning
// RL17 - Egress check per destination port
// RL18 - Drop counters saturate, readable by software
`timescale 1ns/1ps

module stpf_port_filter
  import stpf_pkg::*;
(
  input  wire logic                  clk,                   // Core clock
  input  wire logic                  nrst,                  // Async reset, active low
  // Global configuration
  input  wire logic                  tree_enable,           // Spanning tree filtering on
  input  wire logic                  fwd_from_cpu_enable,   // CPU frames ignore egress state
  input  wire logic [NUM_PROTO-1:0]  proto_addr_enable,     // Per slot CPU trap enable
  input  wire logic                  proto_addr_we,         // Load programmable address
  input  wire logic [MAC_W-1:0]      proto_addr_wdata,      // Programmable trap address
  // Ingress plain state table
  input  wire logic                  src_state_we,          // Write strobe
  input  wire logic [PORT_W-1:0]     src_state_port,        // Port written
  input  wire logic [2:0]            src_state_wdata,       // New state
  // Egress plain state table
  input  wire logic                  egress_tree_state_we,     // Write strobe
  input  wire logic [PORT_W-1:0]     egress_tree_state_port,   // Port written
  input  wire logic [2:0]            egress_tree_state_wdata,  // New state
  // Ingress tree instance table
  input  wire logic                  ing_inst_we,           // Write strobe
  input  wire logic [INST_W-1:0]     ing_inst_sel,          // Instance written
  input  wire logic [PORT_W-1:0]     ing_inst_port,         // Port written
  input  wire logic [1:0]            ing_inst_wdata,        // New state
  // Egress tree instance table
  input  wire logic                  egr_inst_we,           // Write strobe
  input  wire logic [INST_W-1:0]     egr_inst_sel,          // Instance written
  input  wire logic [PORT_W-1:0]     egr_inst_port,         // Port written
  input  wire logic [1:0]            egr_inst_wdata,        // New state
  // Frame from the ingress stage
  input  wire logic                  frm_valid,             // One-cycle frame strobe
  input  wire logic [PORT_W-1:0]     frm_src_port,          // Source port
  input  wire logic [NUM_PORTS-1:0]  frm_dst_mask,          // Candidate destinations
  input  wire logic [MAC_W-1:0]      frm_da,                // Destination MAC
  input  wire logic                  frm_from_cpu,          // Injected by the CPU
  input  wire logic [INST_W-1:0]     instance_table_index,  // From VLAN entry
  // Decision to the egress stage
  output logic                       res_valid,             // One-cycle result strobe
  output logic [NUM_PORTS-1:0]       res_fwd_mask,          // Ports that transmit
  output logic                       res_to_cpu,            // Trap to CPU port
  output logic                       res_learn_ok,          // Source may be learned
  output logic                       res_ingress_drop,      // Dropped at ingress
  // Drop counters
  output logic [CNT_W-1:0]           cnt_ing_listen,        // Ingress Listen drops
  output logic [CNT_W-1:0]           cnt_ing_learning,      // Ingress Learning drops
  output logic [CNT_W-1:0]           cnt_ing_blocking,      // Ingress Blocking drops
  input  wire logic [PORT_W-1:0]     cnt_egr_sel,           // Egress counter chosen
  output logic [CNT_W-1:0]           cnt_egr_value          // Chosen egress count
);

  // ************************************************************
  // State tables
  // ************************************************************
  logic [2:0]       src_state  [NUM_PORTS];            // Ingress plain state
  logic [2:0]       egr_state  [NUM_PORTS];            // Egress plain state
  logic [1:0]       ing_inst   [NUM_INST][NUM_PORTS];  // Ingress instance states
  logic [1:0]       egr_inst   [NUM_INST][NUM_PORTS];  // Egress instance states
  logic [MAC_W-1:0] proto_addr;                        // Programmable trap address

  // Port count at index width, so range checks compare like with like
  localparam logic [PORT_W-1:0] PORT_LIM = PORT_W'(NUM_PORTS);

  // Out of range ports are ignored rather than aliased onto a real port
  wire logic src_wr_ok  = src_state_we && (src_state_port < PORT_LIM);
  wire logic egr_wr_ok  = egress_tree_state_we && (egress_tree_state_port < PORT_LIM);
  wire logic ii_wr_ok   = ing_inst_we && (ing_inst_port < PORT_LIM);
  wire logic ei_wr_ok   = egr_inst_we && (egr_inst_port < PORT_LIM);

  // Plain state tables, one entry per port per direction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        src_state[p] <= STPF_DISABLED;
        egr_state[p] <= STPF_DISABLED;
      end
    end else begin
      if (src_wr_ok) begin
        src_state[src_state_port] <= src_state_wdata;  // RL4
      end
      if (egr_wr_ok) begin
        egr_state[egress_tree_state_port] <= egress_tree_state_wdata;  // RL4
      end
    end
  end

  // Instance tables; reset to Forwarding so plain tree operation is neutral
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_INST; i++) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
          ing_inst[i][p] <= STPF_I_FORWARDING;
          egr_inst[i][p] <= STPF_I_FORWARDING;
        end
      end
    end else begin
      if (ii_wr_ok) begin
        ing_inst[ing_inst_sel][ing_inst_port] <= ing_inst_wdata;
      end
      if (ei_wr_ok) begin
        egr_inst[egr_inst_sel][egr_inst_port] <= egr_inst_wdata;
      end
    end
  end

  // Programmable protocol address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      proto_addr <= PROTO_ADDR_RESET;
    end else if (proto_addr_we) begin
      proto_addr <= proto_addr_wdata;
    end
  end

  // ************************************************************
  // Protocol frame detection
  // ************************************************************
  wire logic proto_hit0 = proto_addr_enable[0] && (frm_da == PROTO_ADDR0);
  wire logic proto_hit1 = proto_addr_enable[1] && (frm_da == PROTO_ADDR1);
  wire logic proto_hit2 = proto_addr_enable[2] && (frm_da == proto_addr);
  wire logic is_proto   = proto_hit0 || proto_hit1 || proto_hit2;  // RL2

  // ************************************************************
  // Ingress decision
  // ************************************************************
  wire logic       src_ok   = (frm_src_port < PORT_LIM);
  // Unknown source ports behave as Forwarding so nothing is lost by mistake
  wire logic [2:0] in_stp   = src_ok ? src_state[frm_src_port] : STPF_FORWARDING;
  wire logic [1:0] in_inst  = src_ok ? ing_inst[instance_table_index][frm_src_port]
                                     : STPF_I_FORWARDING;  // RL10

  wire logic stp_listen  = (in_stp == STPF_LISTENING);
  wire logic stp_block   = (in_stp == STPF_BLOCKING);
  wire logic stp_learn   = (in_stp == STPF_LEARNING);
  wire logic inst_learn  = (in_inst == STPF_I_LEARNING);
  wire logic inst_disc   = (in_inst == STPF_I_DISCARDING);

  // Plain state wins the counter choice; instance state only counts otherwise
  wire logic drop_listen = tree_enable && stp_listen;                        // RL7 RL12
  wire logic drop_block  = tree_enable && (stp_block ||
                           (!stp_listen && !stp_learn && inst_disc));        // RL7 RL14
  wire logic drop_learn  = tree_enable && !stp_listen && !stp_block &&
                           (stp_learn || (!inst_disc && inst_learn));        // RL8 RL14
  wire logic ing_drop    = drop_listen || drop_block || drop_learn;

  // Learning follows ingress state only; Learning drops may still learn
  wire logic learn_ok    = !drop_listen && !drop_block;  // RL6 RL16 RL9

  // ************************************************************
  // Egress decision, one check per destination port
  // ************************************************************
  wire logic [NUM_PORTS-1:0] egr_block;   // Port state forbids transmit
  wire logic [NUM_PORTS-1:0] egr_pass;    // Port transmits
  wire logic [NUM_PORTS-1:0] egr_drop;    // Port counts a drop
  wire logic                 cpu_bypass = frm_from_cpu && fwd_from_cpu_enable;  // RL3

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_egr
      wire logic [2:0] e_stp  = egr_state[gp];
      wire logic [1:0] e_inst = egr_inst[instance_table_index][gp];  // RL10
      wire logic       e_bad  = (e_stp == STPF_BLOCKING) || (e_stp == STPF_LISTENING) ||
                                (e_stp == STPF_LEARNING) ||
                                (e_inst == STPF_I_LEARNING) ||
                                (e_inst == STPF_I_DISCARDING);     // RL15
      assign egr_block[gp] = tree_enable && e_bad && !cpu_bypass;  // RL1 RL3
      assign egr_pass[gp]  = frm_dst_mask[gp] && !egr_block[gp];   // RL17
      assign egr_drop[gp]  = frm_valid && !is_proto && !ing_drop &&
                             frm_dst_mask[gp] && egr_block[gp];    // RL12 RL17
    end
  endgenerate

  // Protocol frames are trapped to the CPU and never counted as drops
  wire logic [NUM_PORTS-1:0] next_fwd_mask =
    (is_proto || ing_drop) ? '0 : egr_pass;  // RL7 RL8 RL9

  // ************************************************************
  // Result register
  // ************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      res_valid        <= 1'b0;
      res_fwd_mask     <= '0;
      res_to_cpu       <= 1'b0;
      res_learn_ok     <= 1'b0;
      res_ingress_drop <= 1'b0;
    end else begin
      res_valid        <= frm_valid;
      res_fwd_mask     <= frm_valid ? next_fwd_mask : '0;
      res_to_cpu       <= frm_valid && is_proto;  // RL2
      res_learn_ok     <= frm_valid && learn_ok;  // RL6
      res_ingress_drop <= frm_valid && !is_proto && ing_drop;
    end
  end

  // ************************************************************
  // Drop counters
  // ************************************************************
  // Counting happens in the cycle of the frame, in step with the result
  wire logic inc_listen = frm_valid && !is_proto && drop_listen;  // RL12
  wire logic inc_learn  = frm_valid && !is_proto && drop_learn;   // RL12
  wire logic inc_block  = frm_valid && !is_proto && drop_block;   // RL12

  logic [CNT_W-1:0] egr_cnt [NUM_PORTS];  // One egress count per port

  // Shared ingress counters
  stpf_sat_counter u_cnt_listen (
    .clk   (clk),
    .nrst  (nrst),
    .inc   (inc_listen),
    .value (cnt_ing_listen)
  );  // RL13

  stpf_sat_counter u_cnt_learn (
    .clk   (clk),
    .nrst  (nrst),
    .inc   (inc_learn),
    .value (cnt_ing_learning)
  );

  stpf_sat_counter u_cnt_block (
    .clk   (clk),
    .nrst  (nrst),
    .inc   (inc_block),
    .value (cnt_ing_blocking)
  );

  // Per-port egress counters
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_egr_cnt
      stpf_sat_counter u_cnt_egr (
        .clk   (clk),
        .nrst  (nrst),
        .inc   (egr_drop[gp]),
        .value (egr_cnt[gp])
      );  // RL13 RL15
    end
  endgenerate

  // Read selection; out of range reads as zero
  assign cnt_egr_value = (cnt_egr_sel < PORT_LIM) ? egr_cnt[cnt_egr_sel] : CNT_ZERO;  // RL18

endmodule : stpf_port_filter

// *** testbench/stpf_pipe_model.sv ***
// Ingress stage feeding frames and egress stage collecting decisions
`timescale 1ns/1ps
module stpf_pipe_model
  import stpf_pkg::*;
(
  input  wire logic                 clk,                  // Core clock
  output logic                      frm_valid,            // Frame strobe
  output logic [PORT_W-1:0]         frm_src_port,         // Source port
  output logic [NUM_PORTS-1:0]      frm_dst_mask,         // Candidate destinations
  output logic [MAC_W-1:0]          frm_da,               // Destination MAC
  output logic                      frm_from_cpu,         // Injected by the CPU
  output logic [INST_W-1:0]         instance_table_index, // VLAN entry index
  input  wire logic                 res_valid,            // Result strobe
  input  wire logic [NUM_PORTS-1:0] res_fwd_mask,         // Ports that transmit
  input  wire logic                 res_to_cpu,           // Trap to CPU
  input  wire logic                 res_learn_ok,         // Learning allowed
  input  wire logic                 res_ingress_drop      // Dropped at ingress
);
  // ************************************************************
  // Frame transfer
  // ************************************************************
  // Idle lines at time zero
  initial begin
    frm_valid = 1'b0;
    {frm_src_port, frm_dst_mask, frm_da, frm_from_cpu, instance_table_index} = '0;
  end
  // One frame, decision taken one cycle after it
  task automatic send(input logic [3:0] src, input logic [11:0] dst, input logic [47:0] da,
                      input logic cpu, input logic [3:0] idx, output logic [15:0] res);
    @(posedge clk);
    frm_valid <= 1'b1;
    {frm_src_port, frm_dst_mask, frm_da, frm_from_cpu, instance_table_index} <=
      {src, dst, da, cpu, idx};
    @(posedge clk);
    frm_valid <= 1'b0;
    // Inverted idle data, so a stale field can never pass for a fresh one
    {frm_src_port, frm_dst_mask, frm_da, frm_from_cpu, instance_table_index} <=
      ~{src, dst, da, cpu, idx};
    #1;
    res = {res_valid, res_to_cpu, res_learn_ok, res_ingress_drop, res_fwd_mask};
  endtask : send
endmodule : stpf_pipe_model

// *** testbench/stpf_port_filter_sva.sv ***
// Checker of frame decisions and ingress drop counters
`timescale 1ns/1ps
module stpf_port_filter_sva
  import stpf_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 tree_enable,
  input wire logic [NUM_PROTO-1:0] proto_addr_enable,
  input wire logic                 frm_valid,
  input wire logic [NUM_PORTS-1:0] frm_dst_mask,
  input wire logic [MAC_W-1:0]     frm_da,
  input wire logic                 res_valid,
  input wire logic [NUM_PORTS-1:0] res_fwd_mask,
  input wire logic                 res_to_cpu,
  input wire logic                 res_learn_ok,
  input wire logic                 res_ingress_drop,
  input wire logic [CNT_W-1:0]     cnt_ing_listen,
  input wire logic [CNT_W-1:0]     cnt_ing_learning,
  input wire logic [CNT_W-1:0]     cnt_ing_blocking
);
  // Frame aimed at an enabled fixed trap address
  wire logic fixed_hit;
  assign fixed_hit = (proto_addr_enable[0] && frm_da == PROTO_ADDR0) ||
                     (proto_addr_enable[1] && frm_da == PROTO_ADDR1);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_tree_off_pass: assert property (
    frm_valid && !tree_enable |=> res_valid && !res_ingress_drop && res_learn_ok)
    else $error("frame filtered while tree off");
  chk_proto_trap: assert property (
    frm_valid && fixed_hit |=> res_valid && res_to_cpu && res_fwd_mask == '0)
    else $error("protocol frame not trapped");
  chk_no_trap: assert property (
    frm_valid && frm_da != PROTO_ADDR0 && frm_da != PROTO_ADDR1 && !proto_addr_enable[2]
    |=> !res_to_cpu) else $error("ordinary frame trapped");
  chk_block_count: assert property (
    $changed(cnt_ing_blocking) |-> res_valid && res_ingress_drop && !res_learn_ok &&
    cnt_ing_blocking == $past(cnt_ing_blocking) + CNT_ONE) else $error("blocking count bad");
  chk_learn_count: assert property (
    $changed(cnt_ing_learning) |-> res_ingress_drop && res_learn_ok &&
    cnt_ing_learning == $past(cnt_ing_learning) + CNT_ONE) else $error("learning count bad");
  chk_listen_count: assert property (
    $changed(cnt_ing_listen) |-> res_ingress_drop && !res_learn_ok &&
    cnt_ing_listen == $past(cnt_ing_listen) + CNT_ONE) else $error("listen count bad");
  chk_drop_empty: assert property (
    res_ingress_drop |-> res_fwd_mask == '0 && !res_to_cpu) else $error("dropped frame sent");
  chk_mask_subset: assert property (
    res_valid |-> (res_fwd_mask & ~$past(frm_dst_mask)) == '0) else $error("mask too wide");
  chk_count_up: assert property (
    cnt_ing_blocking >= $past(cnt_ing_blocking) && cnt_ing_listen >= $past(cnt_ing_listen))
    else $error("counter went down");
endmodule : stpf_port_filter_sva
bind stpf_port_filter stpf_port_filter_sva stpf_port_filter_sva_inst (.clk, .nrst,
  .tree_enable, .proto_addr_enable, .frm_valid, .frm_dst_mask, .frm_da, .res_valid,
  .res_fwd_mask, .res_to_cpu, .res_learn_ok, .res_ingress_drop, .cnt_ing_listen,
  .cnt_ing_learning, .cnt_ing_blocking);

// *** testbench/stpf_port_filter_tb.sv ***
// Self-checking bench of the spanning tree port filter
`timescale 1ns/1ps
module stpf_port_filter_tb;
  import stpf_pkg::*;
  logic clk = 0, nrst = 0, tree_en = 0, cpu_en = 0, pa_we = 0;
  logic [2:0] pa_en = PROTO_EN_RESET, wr_st = '0;
  logic [3:0] wr_we = '0, wr_sel = '0, wr_port = '0, egr_sel = '0;
  logic [47:0] pa_data = '0;
  logic frm_valid, frm_from_cpu, res_valid, res_to_cpu, res_learn_ok, res_ingress_drop;
  logic [3:0] frm_src_port, instance_table_index;
  logic [11:0] frm_dst_mask, res_fwd_mask;
  logic [47:0] frm_da;
  logic [31:0] c_lis, c_lrn, c_blk, c_egr;
  int n_fail = 0, n_compared = 0, cycles = 0;
  localparam logic [47:0] DA = 48'h020000000001; // Ordinary unicast address
  // Clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  stpf_port_filter stpf_port_filter_inst (.clk, .nrst, .tree_enable(tree_en),
    .fwd_from_cpu_enable(cpu_en), .proto_addr_enable(pa_en), .proto_addr_we(pa_we),
    .proto_addr_wdata(pa_data), .src_state_we(wr_we[0]), .src_state_port(wr_port),
    .src_state_wdata(wr_st), .egress_tree_state_we(wr_we[1]), .egress_tree_state_port(wr_port),
    .egress_tree_state_wdata(wr_st), .ing_inst_we(wr_we[2]), .ing_inst_sel(wr_sel),
    .ing_inst_port(wr_port), .ing_inst_wdata(wr_st[1:0]), .egr_inst_we(wr_we[3]),
    .egr_inst_sel(wr_sel), .egr_inst_port(wr_port), .egr_inst_wdata(wr_st[1:0]), .frm_valid,
    .frm_src_port, .frm_dst_mask, .frm_da, .frm_from_cpu, .instance_table_index, .res_valid,
    .res_fwd_mask, .res_to_cpu, .res_learn_ok, .res_ingress_drop, .cnt_ing_listen(c_lis),
    .cnt_ing_learning(c_lrn), .cnt_ing_blocking(c_blk), .cnt_egr_sel(egr_sel),
    .cnt_egr_value(c_egr));
  stpf_pipe_model stpf_pipe_model_inst (.clk, .frm_valid, .frm_src_port, .frm_dst_mask,
    .frm_da, .frm_from_cpu, .instance_table_index, .res_valid, .res_fwd_mask, .res_to_cpu,
    .res_learn_ok, .res_ingress_drop);
  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // Table write: 0 ingress plain, 1 egress plain, 2 ingress instance, 3 egress instance
  task automatic wr(input int k, input logic [3:0] sel, input logic [3:0] port,
                    input logic [2:0] st);
    @(posedge clk);
    wr_we <= 4'h1 << k;
    wr_sel <= sel;
    wr_port <= port;
    wr_st <= st;
    @(posedge clk);
    wr_we <= 4'h0;
  endtask : wr
  // Expected result packs valid, trap, learn, drop and the forward mask
  task automatic fr(input logic [3:0] src, input logic [11:0] dst, input logic [47:0] da,
                    input logic cpu, input logic [3:0] idx, input logic [15:0] e);
    logic [15:0] g;
    stpf_pipe_model_inst.send(src, dst, da, cpu, idx, g);
    cmp("frame result", {16'h0000, e}, {16'h0000, g});
  endtask : fr
  task automatic cnt(input logic [31:0] lis, input logic [31:0] lrn, input logic [31:0] blk);
    cmp("listen drops", lis, c_lis);
    cmp("learning drops", lrn, c_lrn);
    cmp("blocking drops", blk, c_blk);
  endtask : cnt
  task automatic egr(input logic [3:0] p, input logic [31:0] e);
    @(posedge clk);
    egr_sel <= p;
    @(posedge clk);
    #1;
    cmp("egress drops", e, c_egr);
  endtask : egr
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    cnt(32'h0, 32'h0, 32'h0);
    wr(0, 4'h0, 4'h2, STPF_BLOCKING);
    fr(4'h2, 12'h003, DA, 1'b0, 4'h0, 16'hA003);
    $display("test tree off done");
    @(posedge clk) tree_en <= 1'b1;
    fr(4'h2, 12'h003, PROTO_ADDR0, 1'b0, 4'h0, 16'hC000);
    fr(4'h2, 12'h003, PROTO_ADDR1, 1'b0, 4'h0, 16'hC000);
    @(posedge clk);
    pa_data <= 48'h0A0B0C0D0E0F;
    pa_we <= 1'b1;
    pa_en <= 3'h4;
    fr(4'h2, 12'h003, 48'h0A0B0C0D0E0F, 1'b0, 4'h0, 16'hC000);
    @(posedge clk) pa_we <= 1'b0;
    fr(4'h2, 12'h003, PROTO_ADDR0, 1'b0, 4'h0, 16'h9000);
    @(posedge clk) pa_en <= PROTO_EN_RESET;
    $display("test protocol trap done");
    wr(0, 4'h0, 4'h3, STPF_LISTENING);
    wr(0, 4'h0, 4'h4, STPF_LEARNING);
    fr(4'h2, 12'h003, DA, 1'b0, 4'h0, 16'h9000);
    fr(4'h3, 12'h003, DA, 1'b0, 4'h0, 16'h9000);
    fr(4'h4, 12'h003, DA, 1'b0, 4'h0, 16'hB000);
    wr(2, 4'h5, 4'h9, STPF_I_DISCARDING);
    wr(2, 4'h5, 4'hA, STPF_I_LEARNING);
    fr(4'h9, 12'h003, DA, 1'b0, 4'h5, 16'h9000);
    fr(4'hA, 12'h003, DA, 1'b0, 4'h5, 16'hB000);
    fr(4'h9, 12'h003, DA, 1'b0, 4'h0, 16'hA003);
    cnt(32'h1, 32'h2, 32'h3);
    $display("test ingress states done");
    wr(0, 4'h0, 4'h5, STPF_FORWARDING);
    wr(1, 4'h0, 4'h6, STPF_BLOCKING);
    wr(3, 4'h5, 4'h7, STPF_I_DISCARDING);
    wr(3, 4'h5, 4'h8, STPF_I_LEARNING);
    fr(4'h5, 12'h1C1, DA, 1'b0, 4'h5, 16'hA001);
    fr(4'h6, 12'h001, DA, 1'b0, 4'h0, 16'hA001);
    wr(1, 4'h0, 4'h9, STPF_LISTENING);
    wr(1, 4'h0, 4'hA, STPF_LEARNING);
    fr(4'h0, 12'h601, DA, 1'b0, 4'h0, 16'hA001);
    fr(4'hB, 12'h040, DA, 1'b1, 4'h0, 16'hA000);
    @(posedge clk) cpu_en <= 1'b1;
    fr(4'hB, 12'h040, DA, 1'b1, 4'h0, 16'hA040);
    egr(4'h6, 32'h2);
    egr(4'h7, 32'h1);
    egr(4'h8, 32'h1);
    egr(4'h0, 32'h0);
    egr(4'h9, 32'h1);
    egr(4'hA, 32'h1);
    egr(4'hF, 32'h0);
    cnt(32'h1, 32'h2, 32'h3);
    $display("test egress states done");
    end_of_test();
  end
endmodule : stpf_port_filter_tb
